/* File: hdl/tap_pkg.sv */
// Shared constants, state type and next-state decode for the scan port.
// Assumes a single scan port per device; no clock or reset lives here.
package tap_pkg;

	// Controller states of the sixteen-state scan sequencer
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} tap_state_type;

	// Instruction width and codes
	localparam int IR_WIDTH = 3;
	localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 3'h0;
	localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 3'h1;
	localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 3'h2;
	localparam logic [IR_WIDTH-1:0] INSTR_CLAMP = 3'h3;
	localparam logic [IR_WIDTH-1:0] INSTR_HIGHZ = 3'h4;
	localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 3'h7;
	// Fixed pattern captured into the instruction shifter, low bits 01
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 3'h1;

	// Identification word layout
	localparam int ID_WIDTH = 32;
	localparam int ID_REV_WIDTH = 4;
	localparam int ID_PART_WIDTH = 16;
	localparam int ID_MAKER_WIDTH = 11;
	localparam logic ID_MARKER = 1'h1;

	// Reset values of single-bit test state
	localparam logic BIT_CLEAR = 1'h0;

	// Next controller state from the present one and the mode-select level
	function automatic tap_state_type tap_next(input tap_state_type s,
		input logic tms);
		tap_state_type n;
		n = ST_RESET;
		unique case (s)
			ST_RESET: n = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
		endcase
		return n;
	endfunction

endpackage

/* File: hdl/boundary_scan_tap.sv */
// Boundary-scan test access port: sequencer, instruction, bypass,
// identification and boundary registers, plus the pin output muxing.
// Assumes the scan controller drives test clock, mode select and serial
// in; the core logic runs on clk_in and drives pins through this block.
`timescale 1ns/100ps

module boundary_scan_tap
	import tap_pkg::*;
#(
	parameter int NUM_OUT = 8,
	parameter int NUM_IN = 8,
	parameter logic [ID_REV_WIDTH-1:0] ID_REVISION = 4'h0,
	parameter logic [ID_PART_WIDTH-1:0] ID_PART = 16'h0A5A,
	parameter logic [ID_MAKER_WIDTH-1:0] ID_MAKER = 11'h2A5
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic test_clock_in,
	input wire logic test_reset_n,
	input wire logic test_mode_select_in,
	input wire logic test_serial_in,
	output logic test_serial_out,
	output logic test_serial_oe_out,
	input wire logic [NUM_OUT-1:0] core_data_in,
	input wire logic [NUM_OUT-1:0] core_enable_in,
	input wire logic [NUM_IN-1:0] pin_level_in,
	output logic [NUM_OUT-1:0] pin_data_out,
	output logic [NUM_OUT-1:0] pin_enable_out
);

	// Capture takes pins and the core's own drive, so SAMPLE shows what
	// the device would put on the pins, not what the latches hold.
	// Shifting a full chain takes BSR_WIDTH rising test clocks; a short
	// shift leaves the low cells holding stale capture data, which then
	// reaches the latches at the next update.
	// The latches themselves only move on update, never while shifting.
	// Cell order from serial out: pins first, core data, then enables.
	// Widths follow the parameters, so a count change keeps the order.
	// Boundary chain: input cells low, then output data, then enables
	localparam int BSR_WIDTH = NUM_IN + 2 * NUM_OUT;
	localparam int BSR_DATA_LO = NUM_IN;
	localparam int BSR_EN_LO = NUM_IN + NUM_OUT;
	// Arbitrary identification value, marker bit in the lowest place
	localparam logic [ID_WIDTH-1:0] ID_WORD =
		{ID_REVISION, ID_PART, ID_MAKER, ID_MARKER};
	localparam logic [BSR_WIDTH-1:0] BSR_CLEAR = '0;
	localparam logic [ID_WIDTH-1:0] ID_CLEAR = '0;
	localparam logic [NUM_OUT-1:0] OUT_CLEAR = '0;
	localparam logic [NUM_IN-1:0] IN_CLEAR = '0;

	// Everything below up to the pin side runs on the test clock alone.
	// Only the async test reset clears it; the system reset does not, so
	// a scan in progress survives a core reset.
	// The sequencer and shifters use the rising edge, while the current
	// instruction, the latches and serial out use the falling edge.
	// Test clock domain state
	tap_state_type state_r, state_nxt;
	logic [IR_WIDTH-1:0] ir_shift_r, ir_shift_nxt;
	logic [IR_WIDTH-1:0] ir_r, ir_nxt;
	logic bypass_r, bypass_nxt;
	logic [ID_WIDTH-1:0] id_shift_r, id_shift_nxt;
	logic [BSR_WIDTH-1:0] bsr_shift_r, bsr_shift_nxt;
	logic [BSR_WIDTH-1:0] bsr_hold_r, bsr_hold_nxt;
	logic upd_toggle_r, upd_toggle_nxt;
	logic drive_bsr_r, drive_bsr_nxt;
	logic float_r, float_nxt;
	logic tdo_r, tdo_nxt;
	logic tdo_oe_r, tdo_oe_nxt;
	logic [NUM_IN-1:0] pin_meta_r, pin_sync_r;
	logic [NUM_OUT-1:0] cdat_meta_r, cdat_sync_r;
	logic [NUM_OUT-1:0] cen_meta_r, cen_sync_r;
	logic sel_bsr, sel_id;
	logic dr_serial;

	// Only flags and a toggle cross from the test side; wider values are
	// read once the toggle says they are still.
	// System clock domain state
	logic drive_meta_r, drive_sync_r;
	logic float_meta_r, float_sync_r;
	logic tog_meta_r, tog_sync_r, tog_seen_r;
	logic [NUM_OUT-1:0] hold_data_r, hold_data_nxt;
	logic [NUM_OUT-1:0] hold_en_r, hold_en_nxt;
	logic [NUM_OUT-1:0] pin_data_nxt, pin_enable_nxt;

	// Pin levels and core drive arrive from other domains: two stages
	// The core drive is only ever captured, never used to steer the
	// sequencer, so a torn capture during a pin change costs one sample.
	// Capture-DR sees values two test clocks old; a controller that
	// changes pins must allow for that before capturing.
	// Test reset clears the stages; they refill from the pins two test clocks later, before any capture can follow it.
	always_ff @(posedge test_clock_in or negedge test_reset_n)
	begin
		if (!test_reset_n)
		begin
			pin_meta_r <= IN_CLEAR;
			pin_sync_r <= IN_CLEAR;
			cdat_meta_r <= OUT_CLEAR;
			cdat_sync_r <= OUT_CLEAR;
			cen_meta_r <= OUT_CLEAR;
			cen_sync_r <= OUT_CLEAR;
		end
		else
		begin
			pin_meta_r <= pin_level_in;
			pin_sync_r <= pin_meta_r;
			cdat_meta_r <= core_data_in;
			cdat_sync_r <= cdat_meta_r;
			cen_meta_r <= core_enable_in;
			cen_sync_r <= cen_meta_r;
		end
	end

	// Register selection; codes without a register fall to bypass
	// Unassigned codes therefore act like bypass with normal pins, which
	// keeps a mistyped instruction from disturbing the board.
	// Selection follows the current instruction, not the shifted one.
	always_comb
	begin
		sel_bsr = (ir_r == INSTR_EXTEST) || (ir_r == INSTR_SAMPLE);
		sel_id = (ir_r == INSTR_IDCODE);
		if (sel_bsr)
			dr_serial = bsr_shift_r[0];
		else if (sel_id)
			dr_serial = id_shift_r[0];
		else
			dr_serial = bypass_r;
	end

	// Rising-edge next values: sequencer and shift stages
	// Transitions come from the shared decode, so the checker's shadow
	// sequencer and this one cannot drift apart.
	// Data branch: select, exit, pause and return to shift
	// Instruction branch: select, exit, pause and return to shift
	always_comb
	begin
		state_nxt = tap_next(state_r, test_mode_select_in);
		ir_shift_nxt = ir_shift_r;
		bypass_nxt = bypass_r;
		id_shift_nxt = id_shift_r;
		bsr_shift_nxt = bsr_shift_r;
		// Select, exit and pause states leave every register alone
		if (state_r == ST_CAP_IR)
			ir_shift_nxt = IR_CAPTURE_VALUE;
		if (state_r == ST_SHIFT_IR)
			ir_shift_nxt = {test_serial_in, ir_shift_r[IR_WIDTH-1:1]};
		if (state_r == ST_CAP_DR)
		begin
			if (sel_bsr)
				bsr_shift_nxt = {cen_sync_r, cdat_sync_r, pin_sync_r};
			else if (sel_id)
				id_shift_nxt = ID_WORD;
			else
				bypass_nxt = BIT_CLEAR;
		end
		if (state_r == ST_SHIFT_DR)
		begin
			if (sel_bsr)
				bsr_shift_nxt = {test_serial_in, bsr_shift_r[BSR_WIDTH-1:1]};
			else if (sel_id)
				id_shift_nxt = {test_serial_in, id_shift_r[ID_WIDTH-1:1]};
			else
				bypass_nxt = test_serial_in;
		end
	end

	// Rising-edge registers; test reset puts the sequencer in reset state
	// Shifters clear on test reset so a first scan never shows unknowns;
	// the instruction shifter starts at its capture pattern for the same
	// reason.
	// Bypass captures zero, so the first bit through it is known.
	always_ff @(posedge test_clock_in or negedge test_reset_n)
	begin
		if (!test_reset_n)
		begin
			state_r <= ST_RESET;
			ir_shift_r <= IR_CAPTURE_VALUE;
			bypass_r <= BIT_CLEAR;
			id_shift_r <= ID_CLEAR;
			bsr_shift_r <= BSR_CLEAR;
		end
		else
		begin
			state_r <= state_nxt;
			ir_shift_r <= ir_shift_nxt;
			bypass_r <= bypass_nxt;
			id_shift_r <= id_shift_nxt;
			bsr_shift_r <= bsr_shift_nxt;
		end
	end

	// Falling-edge next values: latches, pin mode flags and serial out
	// Reading the state on the falling edge gives half a test clock
	// between the sequencer moving and the instruction changing, so the
	// selection never switches in the middle of a capture.
	// The mode flags look at the next instruction so that they change on
	// the same edge as the instruction, not one clock later.
	// The toggle flips on every boundary update; the pin side only needs
	// to see that it moved, not how often.
	always_comb
	begin
		ir_nxt = ir_r;
		bsr_hold_nxt = bsr_hold_r;
		upd_toggle_nxt = upd_toggle_r;
		if (state_r == ST_RESET)
			ir_nxt = INSTR_IDCODE;
		else if (state_r == ST_UPD_IR)
			ir_nxt = ir_shift_r;
		// Latches only move on update, so the pins never see shifting
		if (state_r == ST_UPD_DR && sel_bsr)
		begin
			bsr_hold_nxt = bsr_shift_r;
			upd_toggle_nxt = ~upd_toggle_r;
		end
		drive_bsr_nxt = (ir_nxt == INSTR_EXTEST) || (ir_nxt == INSTR_CLAMP);
		float_nxt = (ir_nxt == INSTR_HIGHZ);
		tdo_oe_nxt = (state_r == ST_SHIFT_IR) || (state_r == ST_SHIFT_DR);
		if (state_r == ST_SHIFT_IR)
			tdo_nxt = ir_shift_r[0];
		else if (state_r == ST_SHIFT_DR)
			tdo_nxt = dr_serial;
		else
			tdo_nxt = tdo_r;
	end

	// Falling-edge registers; half a test clock of setup for the controller
	// Serial out holds its last bit outside shifts instead of returning to
	// a fixed level; the enable tells the far side when it is meaningful.
	// Test reset clears the mode flags here, so the pins return to normal
	// operation a few system clocks later.
	always_ff @(negedge test_clock_in or negedge test_reset_n)
	begin
		if (!test_reset_n)
		begin
			ir_r <= INSTR_IDCODE;
			bsr_hold_r <= BSR_CLEAR;
			upd_toggle_r <= BIT_CLEAR;
			drive_bsr_r <= BIT_CLEAR;
			float_r <= BIT_CLEAR;
			tdo_r <= BIT_CLEAR;
			tdo_oe_r <= BIT_CLEAR;
		end
		else
		begin
			ir_r <= ir_nxt;
			bsr_hold_r <= bsr_hold_nxt;
			upd_toggle_r <= upd_toggle_nxt;
			drive_bsr_r <= drive_bsr_nxt;
			float_r <= float_nxt;
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end

	// Serial out and its enable leave straight from falling-edge flops.
	// Data changes half a clock ahead of the far side's rising sample,
	// which is the setup the link expects.
	assign test_serial_out = tdo_r;
	assign test_serial_oe_out = tdo_oe_r;

	// Mode levels and the update toggle cross into the system clock
	// Each flag is a single bit, so two stages are enough; the boundary
	// latches are many bits and cross only behind the toggle below.
	// A third stage keeps the previous toggle level for edge detection.
	// After system reset a false toggle edge can occur once; it is
	// harmless because it only copies latches that are already settled.
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			drive_meta_r <= BIT_CLEAR;
			drive_sync_r <= BIT_CLEAR;
			float_meta_r <= BIT_CLEAR;
			float_sync_r <= BIT_CLEAR;
			tog_meta_r <= BIT_CLEAR;
			tog_sync_r <= BIT_CLEAR;
			tog_seen_r <= BIT_CLEAR;
		end
		else
		begin
			drive_meta_r <= drive_bsr_r;
			drive_sync_r <= drive_meta_r;
			float_meta_r <= float_r;
			float_sync_r <= float_meta_r;
			tog_meta_r <= upd_toggle_r;
			tog_sync_r <= tog_meta_r;
			tog_seen_r <= tog_sync_r;
		end
	end

	// Copy the boundary latches once the toggle has settled; the latch
	// is stable for several test clocks after an update, so no tearing
	// Two updates closer than four system clocks could merge into one
	// copy; the later values still win, so only the earlier pattern is
	// lost.
	// Normal mode reads the core drive directly: it is already on this
	// clock and needs no synchroniser.
	always_comb
	begin
		hold_data_nxt = hold_data_r;
		hold_en_nxt = hold_en_r;
		if (tog_sync_r != tog_seen_r)
		begin
			hold_data_nxt = bsr_hold_r[BSR_DATA_LO +: NUM_OUT];
			hold_en_nxt = bsr_hold_r[BSR_EN_LO +: NUM_OUT];
		end
		// Float wins over drive; normal mode passes the core through
		if (float_sync_r)
		begin
			pin_data_nxt = core_data_in;
			pin_enable_nxt = OUT_CLEAR;
		end
		else if (drive_sync_r)
		begin
			pin_data_nxt = hold_data_nxt;
			pin_enable_nxt = hold_en_nxt;
		end
		else
		begin
			pin_data_nxt = core_data_in;
			pin_enable_nxt = core_enable_in;
		end
	end

	// Pin drive registers
	// Every pin output leaves a flop on the system clock, so the pads see
	// no glitch while the modes switch.
	// System reset releases all pins; the core then drives them on the
	// following clock.
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			hold_data_r <= OUT_CLEAR;
			hold_en_r <= OUT_CLEAR;
			pin_data_out <= OUT_CLEAR;
			pin_enable_out <= OUT_CLEAR;
		end
		else
		begin
			hold_data_r <= hold_data_nxt;
			hold_en_r <= hold_en_nxt;
			pin_data_out <= pin_data_nxt;
			pin_enable_out <= pin_enable_nxt;
		end
	end

endmodule

/* File: testbench/tap_sva.sv */
// Checker for the scan port: serial out timing and pin muxing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module tap_sva
	import tap_pkg::*;
#(
	parameter int NUM_OUT = 8
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic test_clock_in,
	input wire logic test_reset_n,
	input wire logic test_mode_select_in,
	input wire logic test_serial_out,
	input wire logic test_serial_oe_out,
	input wire logic [NUM_OUT-1:0] core_data_in,
	input wire logic [NUM_OUT-1:0] core_enable_in,
	input wire logic [NUM_OUT-1:0] pin_data_out,
	input wire logic [NUM_OUT-1:0] pin_enable_out
);
	tap_state_type st_r, st_nxt;
	logic id_r, id_nxt, shift_w;
	// Shadow sequencer; tracks whether the identify code is still current
	always_comb
	begin
		st_nxt = tap_next(st_r, test_mode_select_in);
		id_nxt = st_nxt == ST_RESET ? 1'h1 : st_nxt == ST_UPD_IR ? 1'h0 : id_r;
	end
	always_ff @(posedge test_clock_in or negedge test_reset_n)
		if (!test_reset_n)
		begin
			st_r <= ST_RESET;
			id_r <= 1'h1;
		end
		else
		begin
			st_r <= st_nxt;
			id_r <= id_nxt;
		end
	assign shift_w = st_r == ST_SHIFT_DR || st_r == ST_SHIFT_IR;
	// Values at a rising edge were set on the falling edge just before
	default clocking @(posedge test_clock_in); endclocking
	default disable iff (!test_reset_n);
	property p_oe;
		test_serial_oe_out == shift_w;
	endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	property p_hold;
		!shift_w |-> $stable(test_serial_out);
	endproperty
	a_hold: assert property (p_hold) else $error("out moved");
	property p_cap;
		st_r == ST_SHIFT_IR && $past(st_r) == ST_CAP_IR |-> test_serial_out;
	endproperty
	a_cap: assert property (p_cap) else $error("capture bit0");
	property p_cap2;
		st_r == ST_SHIFT_IR && $past(st_r) == ST_SHIFT_IR &&
			$past(st_r, 2) == ST_CAP_IR |-> !test_serial_out;
	endproperty
	a_cap2: assert property (p_cap2) else $error("capture bit1");
	property p_id;
		id_r && st_r == ST_SHIFT_DR && $past(st_r) == ST_CAP_DR
			|-> test_serial_out;
	endproperty
	a_id: assert property (p_id) else $error("id marker");
	// A held test reset keeps serial out and its enable low and leaves the pins in normal operation
	property p_trst;
		@(posedge clk_in) disable iff (!rstn_in)
		!test_reset_n |-> !test_serial_oe_out && !test_serial_out;
	endproperty
	a_trst: assert property (p_trst) else $error("reset out");
	property p_norm_d;
		@(posedge clk_in) disable iff (!rstn_in)
		($past(rstn_in) && !test_reset_n) [*8]
			|-> pin_data_out == $past(core_data_in);
	endproperty
	a_norm_d: assert property (p_norm_d) else $error("pin data");
	property p_norm_e;
		@(posedge clk_in) disable iff (!rstn_in)
		($past(rstn_in) && !test_reset_n) [*8]
			|-> pin_enable_out == $past(core_enable_in);
	endproperty
	a_norm_e: assert property (p_norm_e) else $error("pin enable");
	c_ir: cover property (st_r == ST_UPD_IR);
	c_pause: cover property (st_r == ST_PAUSE_DR);
	c_dr: cover property (st_r == ST_SHIFT_DR);
endmodule
bind boundary_scan_tap tap_sva #(.NUM_OUT(NUM_OUT)) u_sva (.clk_in, .rstn_in,
	.test_clock_in, .test_reset_n, .test_mode_select_in, .test_serial_out,
	.test_serial_oe_out, .core_data_in, .core_enable_in, .pin_data_out,
	.pin_enable_out);

/* File: testbench/scan_master.sv */
// Scan controller model: test clock, mode select, serial in and reset.
// Assumes serial out is driven only while its enable is high.
`timescale 1ns/100ps
module scan_master (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_in
);
	logic last_r = 1'h0;
	wire logic tdo_w;
	// A released line shows the opposite level, never a stale copy
	assign tdo_w = tdo_oe_in ? tdo_in : ~last_r;
	always @(posedge tck_out)
		if (tdo_oe_in)
			last_r <= tdo_in;
	// Clock stands low outside frames
	initial
	begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h0;
		trst_n_out = 1'h0;
	end
	task automatic step(input logic t, input logic d, output logic o);
		tms_out = t;
		tdi_out = d;
		#7.5 tck_out = 1'h1;
		o = tdo_w;
		#7.5 tck_out = 1'h0;
	endtask
	// Reset is held long enough for the pin side to see it
	task automatic pulse_reset;
		logic o;
		trst_n_out = 1'h0;
		#250 step(1'h1, 1'h0, o);
		// Release apart from the falling edge the step just made
		#5 trst_n_out = 1'h1;
	endtask
	// From idle into a shift state
	task automatic enter(input logic ir);
		logic o;
		step(1'h1, 1'h0, o);
		if (ir)
			step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask
	// Last bit leaves through exit-1 with mode select high
	task automatic scan(input int n, input logic [63:0] din,
		output logic [63:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
	endtask
	task automatic leave;
		logic o;
		step(1'h1, 1'h0, o);
		step(1'h0, 1'h0, o);
	endtask
endmodule

/* File: testbench/boundary_scan_tap_test.sv */
// Testbench for the scan port: instruction, data and pin scenarios.
// Assumes the scan controller model drives every test pin.
`timescale 1ns/100ps
module boundary_scan_tap_test;
	import tap_pkg::*;
	localparam int BSR = 24;
	// Arbitrary identification fields
	localparam logic [3:0] REV = 4'h3;
	localparam logic [15:0] PART = 16'h1234;
	localparam logic [10:0] MAKER = 11'h155;
	localparam logic [63:0] ID = {32'h0, REV, PART, MAKER, 1'h1};
	logic clk_in = 1'h0;
	logic rstn_in = 1'h0;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, o;
	logic [7:0] core_d = '0, core_e = '0, pins = '0, pin_d, pin_e;
	logic [63:0] got;
	int errors = 0, total_checks = 0, cycles = 0;
	always #12.5 clk_in = ~clk_in;
	boundary_scan_tap #(.ID_REVISION(REV), .ID_PART(PART), .ID_MAKER(MAKER))
		DUT (.clk_in, .rstn_in, .test_clock_in(tck), .test_reset_n(trst_n),
		.test_mode_select_in(tms), .test_serial_in(tdi), .test_serial_out(tdo),
		.test_serial_oe_out(tdo_oe), .core_data_in(core_d),
		.core_enable_in(core_e), .pin_level_in(pins), .pin_data_out(pin_d),
		.pin_enable_out(pin_e));
	scan_master ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.trst_n_out(trst_n), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
	task automatic check(input string what, input logic [63:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Guard against a hung handshake
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			close_out;
		end
	end
	task automatic load(input logic [2:0] code);
		ctl.enter(1'h1);
		ctl.scan(3, {61'h0, code}, got);
		check("ir capture", got, 64'h1);
		ctl.leave;
	endtask
	task automatic read_id;
		ctl.enter(1'h0);
		ctl.scan(32, 64'h0, got);
		check("id", got, ID);
		ctl.leave;
	endtask
	task automatic t_id;
		ctl.pulse_reset;
		ctl.step(1'h0, 1'h0, o);
		read_id;
		#1;
		check("idle enable", tdo_oe, 64'h0);
		$display("t_id done");
	endtask
	// Pause in mid-scan must not shift the one-bit path
	task automatic t_bypass;
		logic [2:0] codes [4] = '{INSTR_BYPASS, INSTR_HIGHZ, INSTR_CLAMP, 3'h5};
		foreach (codes[i])
		begin
			load(codes[i]);
			ctl.enter(1'h0);
			ctl.scan(2, 64'h3, got);
			check("bypass a", got, 64'h2);
			ctl.step(1'h0, 1'h0, o);
			ctl.step(1'h0, 1'h0, o);
			ctl.step(1'h1, 1'h0, o);
			ctl.step(1'h0, 1'h0, o);
			ctl.scan(2, 64'h0, got);
			check("bypass b", got, 64'h1);
			ctl.leave;
		end
		$display("t_bypass done");
	endtask
	task automatic t_pins;
		@(negedge clk_in);
		{core_e, core_d, pins} = 24'hC35A96;
		load(INSTR_SAMPLE);
		repeat (10) @(negedge clk_in);
		check("sample pins", {pin_e, pin_d}, 16'hC35A);
		ctl.enter(1'h0);
		ctl.scan(BSR, 64'h0FA500, got);
		check("bsr", got, 64'hC35A96);
		ctl.leave;
		load(INSTR_EXTEST);
		repeat (10) @(negedge clk_in);
		check("extest", {pin_e, pin_d}, 16'h0FA5);
		load(INSTR_CLAMP);
		@(negedge clk_in);
		core_d = 8'h3C;
		repeat (10) @(negedge clk_in);
		check("clamp", {pin_e, pin_d}, 16'h0FA5);
		load(INSTR_HIGHZ);
		repeat (10) @(negedge clk_in);
		check("highz", pin_e, 64'h0);
		load(INSTR_BYPASS);
		repeat (10) @(negedge clk_in);
		check("bypass pins", {pin_e, pin_d}, 16'hC33C);
		$display("t_pins done");
	endtask
	// Leaving through select-IR with mode select high restores identify
	task automatic t_tlr;
		load(INSTR_EXTEST);
		repeat (3) ctl.step(1'h1, 1'h0, o);
		ctl.step(1'h0, 1'h0, o);
		read_id;
		load(INSTR_EXTEST);
		ctl.pulse_reset;
		@(negedge clk_in);
		check("reset pins", {pin_e, pin_d}, 16'hC33C);
		$display("t_tlr done");
	endtask
	initial
	begin
		repeat (6) @(negedge clk_in);
		rstn_in = 1'h1;
		t_id;
		t_bypass;
		t_pins;
		t_tlr;
		close_out;
	end
endmodule
